// >>> rtl/eight_bit_event_timer.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Function
// - clock select code picks edge or divider
// - reset clears clock select to zero
// - run bit enables counting, clear stops
// - mode bit: match clear or PWM
// - set/clear pair drives output flip-flop
// - set/clear ignored in PWM mode
// - set/clear bits read back as zero
// - bit1: inversion enable or active level
// - output enable gates pin, else low
// - stopping PWM drives output inactive
// - output settings apply at once, running or not
module eight_bit_event_timer
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic external_count_input,
   output logic timer_output_pin
);

   typedef struct packed
   {
      logic ext_meta;
      logic ext_sync;
      logic run;
      logic pwm;
      logic inv_lvl;
      logic oe;
      logic [2:0] clk_sel;
      logic [7:0] cmp;
      logic [7:0] cnt;
      logic out_ff;
      logic pin;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } timer_state_t;

   timer_state_t s;
   timer_state_t n;
   logic tick;
   logic setup_seen;
   logic commit;
   logic wr_mode;
   logic wr_clksel;
   logic wr_cmp;
   logic hit;
   logic match;
   logic pwm_active;
   logic [7:0] wbyte;

   ////////////////////////////////////////////////////////////////////////////
   // count pulse generation
   count_tick_gen u_count_tick_gen
   (
      .clk(clk),
      .rst(rst),
      .ext_level(s.ext_sync),
      .sel(s.clk_sel),
      .run(s.run),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus decode; one wait state so read data leave a flop
   always_comb
   begin
      wbyte = pwdata[7:0];
      setup_seen = psel & penable & ~s.pready;
      commit = psel & penable & s.pready;
      hit = (paddr == event_timer_pkg::MODE_ADDR) | (paddr == event_timer_pkg::CLKSEL_ADDR)
         | (paddr == event_timer_pkg::CMP_ADDR) | (paddr == event_timer_pkg::CNT_ADDR);
      wr_mode = commit & pwrite & (paddr == event_timer_pkg::MODE_ADDR);
      wr_clksel = commit & pwrite & (paddr == event_timer_pkg::CLKSEL_ADDR);
      wr_cmp = commit & pwrite & (paddr == event_timer_pkg::CMP_ADDR);
      match = s.cnt == s.cmp;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      n = s;
      n.ext_meta = external_count_input;
      n.ext_sync = s.ext_meta;
      n.pready = setup_seen;
      n.pslverr = setup_seen & ~hit;
      n.prdata = 32'h00000000;
      if (setup_seen & ~pwrite)
      begin
         if (paddr == event_timer_pkg::MODE_ADDR)
         begin
            // set/clear bits are write-only and read as zero
            n.prdata[event_timer_pkg::RUN_BIT] = s.run;
            n.prdata[event_timer_pkg::PWM_BIT] = s.pwm;
            n.prdata[event_timer_pkg::INV_BIT] = s.inv_lvl;
            n.prdata[event_timer_pkg::OE_BIT] = s.oe;
         end
         else if (paddr == event_timer_pkg::CLKSEL_ADDR)
         begin
            n.prdata[2:0] = s.clk_sel;
         end
         else if (paddr == event_timer_pkg::CMP_ADDR)
         begin
            n.prdata[7:0] = s.cmp;
         end
         else if (paddr == event_timer_pkg::CNT_ADDR)
         begin
            n.prdata[7:0] = s.cnt;
         end
      end

      // counter; a stopped counter is held at zero
      if (!s.run)
      begin
         n.cnt = 8'h00;
      end
      else if (tick)
      begin
         if (!s.pwm && match)
         begin
            n.cnt = 8'h00;
            n.out_ff = s.out_ff ^ s.inv_lvl;
         end
         else
         begin
            n.cnt = s.cnt + 8'h01;
         end
      end

      // a set or clear write wins over a same-cycle toggle
      if (wr_mode)
      begin
         n.run = wbyte[event_timer_pkg::RUN_BIT];
         n.pwm = wbyte[event_timer_pkg::PWM_BIT];
         n.inv_lvl = wbyte[event_timer_pkg::INV_BIT];
         n.oe = wbyte[event_timer_pkg::OE_BIT];
         if (!wbyte[event_timer_pkg::PWM_BIT])
         begin
            // 11 is prohibited and treated as no change
            case ({wbyte[event_timer_pkg::SET_BIT], wbyte[event_timer_pkg::CLR_BIT]})
               2'b10: n.out_ff = 1'b1;
               2'b01: n.out_ff = 1'b0;
               default: n.out_ff = n.out_ff;
            endcase
         end
      end
      if (wr_clksel)
      begin
         // upper bits are not stored, software keeps them zero
         n.clk_sel = wbyte[2:0];
      end
      if (wr_cmp)
      begin
         n.cmp = wbyte;
      end

      // output path built from the next settings so changes show at once
      pwm_active = n.run & (n.cnt < n.cmp);
      if (n.pwm)
      begin
         n.pin = n.oe & (pwm_active ^ n.inv_lvl);
      end
      else
      begin
         n.pin = n.oe & n.out_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.run <= event_timer_pkg::MODE_RESET[event_timer_pkg::RUN_BIT];
         s.pwm <= event_timer_pkg::MODE_RESET[event_timer_pkg::PWM_BIT];
         s.inv_lvl <= event_timer_pkg::MODE_RESET[event_timer_pkg::INV_BIT];
         s.oe <= event_timer_pkg::MODE_RESET[event_timer_pkg::OE_BIT];
         s.clk_sel <= event_timer_pkg::CLKSEL_RESET;
         s.cmp <= event_timer_pkg::CMP_RESET;
      end
      else
      begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign timer_output_pin = s.pin;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_reset_sel;
      rst |=> s.clk_sel == 3'h0;
   endproperty
   a_reset_sel: assert property (disable iff (1'b0) p_reset_sel) else $error("select not cleared");

   property p_stop_clears;
      !s.run |=> s.cnt == 8'h00;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stopped counter not zero");

   property p_run_counts;
      (s.run && tick && !(s.cnt == s.cmp) && !wr_mode) |=> s.cnt == $past(s.cnt) + 8'h01;
   endproperty
   a_run_counts: assert property (p_run_counts) else $error("counter did not advance");

   property p_match_clear;
      (s.run && !s.pwm && tick && match) |=> s.cnt == 8'h00;
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("match did not clear count");

   property p_match_toggle;
      (s.run && !s.pwm && s.inv_lvl && tick && match && !wr_mode) |=> s.out_ff != $past(s.out_ff);
   endproperty
   a_match_toggle: assert property (p_match_toggle) else $error("match did not toggle");

   property p_ff_set;
      (wr_mode && !wbyte[event_timer_pkg::PWM_BIT] && wbyte[3:2] == 2'b10) |=> s.out_ff;
   endproperty
   a_ff_set: assert property (p_ff_set) else $error("set pair did not set");

   property p_pwm_ignore;
      (wr_mode && s.pwm && wbyte[event_timer_pkg::PWM_BIT]) |=> $stable(s.out_ff);
   endproperty
   a_pwm_ignore: assert property (p_pwm_ignore) else $error("pwm mode obeyed set/clear");

   property p_read_zero;
      (pready && $past(paddr) == event_timer_pkg::MODE_ADDR) |-> prdata[3:2] == 2'b00;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("write-only bits read nonzero");

   property p_oe_low;
      !s.oe |-> !timer_output_pin;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("pin high while disabled");

   property p_pwm_level;
      (s.pwm && s.oe) |-> timer_output_pin == ((s.run && s.cnt < s.cmp) ^ s.inv_lvl);
   endproperty
   a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong");

   property p_pwm_stop;
      (s.pwm && !s.run && s.oe) |-> timer_output_pin == s.inv_lvl;
   endproperty
   a_pwm_stop: assert property (p_pwm_stop) else $error("stopped pwm not inactive");

   property p_oe_now;
      wr_mode |=> s.oe == $past(pwdata[0]) ##0 (s.pwm || timer_output_pin == (s.oe & s.out_ff));
   endproperty
   a_oe_now: assert property (p_oe_now) else $error("output setting delayed");

   property p_apb_wait;
      (psel && penable && !pready) |=> pready ##1 !pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("bus answer timing wrong");

   c_match: cover property (s.run && !s.pwm && tick && match);
   c_pwm_high: cover property (s.pwm && s.run && timer_output_pin);
   c_read_cnt: cover property (pready && $past(paddr) == event_timer_pkg::CNT_ADDR);

endmodule

// >>> common/event_timer_pkg.sv
package event_timer_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [31:0] MODE_IDX = 32'h0000ff43;
   localparam logic [31:0] CLKSEL_IDX = 32'h0000ff6a;
   localparam logic [31:0] CMP_IDX = 32'h0000ff44;
   localparam logic [31:0] CNT_IDX = 32'h0000ff45;
   localparam logic [31:0] MODE_ADDR = {MODE_IDX[29:0], 2'b00};
   localparam logic [31:0] CLKSEL_ADDR = {CLKSEL_IDX[29:0], 2'b00};
   localparam logic [31:0] CMP_ADDR = {CMP_IDX[29:0], 2'b00};
   localparam logic [31:0] CNT_ADDR = {CNT_IDX[29:0], 2'b00};

   ////////////////////////////////////////////////////////////////////////////
   // mode control bit positions
   localparam int RUN_BIT = 7;
   localparam int PWM_BIT = 6;
   localparam int SET_BIT = 3;
   localparam int CLR_BIT = 2;
   localparam int INV_BIT = 1;
   localparam int OE_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [2:0] CLKSEL_RESET = 3'h0;
   localparam logic [7:0] CMP_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // count clock select codes
   localparam logic [2:0] SEL_EXT_FALL = 3'h0;
   localparam logic [2:0] SEL_EXT_RISE = 3'h1;
   localparam logic [2:0] SEL_DIV1 = 3'h2;
   localparam logic [2:0] SEL_DIV2 = 3'h3;
   localparam logic [2:0] SEL_DIV4 = 3'h4;
   localparam logic [2:0] SEL_DIV64 = 3'h5;
   localparam logic [2:0] SEL_DIV256 = 3'h6;
   localparam logic [2:0] SEL_DIV8192 = 3'h7;

   // prescaler width and tap positions (log2 of each divide ratio)
   localparam int PRE_W = 13;
   localparam int TAP_DIV2 = 1;
   localparam int TAP_DIV4 = 2;
   localparam int TAP_DIV64 = 6;
   localparam int TAP_DIV256 = 8;
   localparam int TAP_DIV8192 = 13;

endpackage

// >>> rtl/count_tick_gen.sv
`timescale 1ns/1ps
module count_tick_gen
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // selection
   input wire logic ext_level,
   input wire logic [2:0] sel,
   input wire logic run,
   // one-cycle count pulse
   output logic tick
);

   typedef struct packed
   {
      logic [event_timer_pkg::PRE_W-1:0] pre;
      logic ext_prev;
      logic tick;
   } tick_state_t;

   tick_state_t s;
   tick_state_t n;

   ////////////////////////////////////////////////////////////////////////////
   // prescaler runs free, so a stopped timer restarts on an arbitrary phase
   always_comb
   begin
      n = s;
      n.pre = s.pre + 13'h0001;
      n.ext_prev = ext_level;
      case (sel)
         event_timer_pkg::SEL_EXT_FALL: n.tick = run & s.ext_prev & ~ext_level;
         event_timer_pkg::SEL_EXT_RISE: n.tick = run & ~s.ext_prev & ext_level;
         event_timer_pkg::SEL_DIV1: n.tick = run;
         event_timer_pkg::SEL_DIV2: n.tick = run & (&s.pre[event_timer_pkg::TAP_DIV2-1:0]);
         event_timer_pkg::SEL_DIV4: n.tick = run & (&s.pre[event_timer_pkg::TAP_DIV4-1:0]);
         event_timer_pkg::SEL_DIV64: n.tick = run & (&s.pre[event_timer_pkg::TAP_DIV64-1:0]);
         event_timer_pkg::SEL_DIV256: n.tick = run & (&s.pre[event_timer_pkg::TAP_DIV256-1:0]);
         event_timer_pkg::SEL_DIV8192: n.tick = run & (&s.pre[event_timer_pkg::TAP_DIV8192-1:0]);
         default: n.tick = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign tick = s.tick;

   ////////////////////////////////////////////////////////////////////////////
   property p_tick_div1;
      @(posedge clk) disable iff (rst)
      (sel == event_timer_pkg::SEL_DIV1 && run) |=> tick;
   endproperty
   a_tick_div1: assert property (p_tick_div1) else $error("undivided clock gave no tick");

   property p_tick_div4;
      @(posedge clk) disable iff (rst)
      (tick && $past(sel) == event_timer_pkg::SEL_DIV4 && sel == event_timer_pkg::SEL_DIV4)
         |=> !tick [*3];
   endproperty
   a_tick_div4: assert property (p_tick_div4) else $error("divide by 4 ticked too often");

endmodule

// >>> verification/eight_bit_event_timer_bench.sv
`timescale 1ns/1ps
module eight_bit_event_timer_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_in = 1'b0;
   logic timer_output_pin;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] rdata;
   logic serr;
   int per;
   int highs;
   int divs [6] = '{1, 2, 4, 64, 256, 8192};

   always #2.5 clk = ~clk;

   eight_bit_event_timer u_eight_bit_event_timer
   (
      .clk(clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .external_count_input(ext_in),
      .timer_output_pin(timer_output_pin)
   );

   ////////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // request held until the edge where pready is sampled high
   task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         chk("pready", 32'h1, 32'h0);
      end
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // separate writes: mode/level, output enable, flip-flop, run
   task mode_seq(input logic [7:0] lvl, input logic [7:0] ff);
      apb(1'b1, event_timer_pkg::MODE_ADDR, lvl);
      apb(1'b1, event_timer_pkg::MODE_ADDR, lvl | 8'h01);
      apb(1'b1, event_timer_pkg::MODE_ADDR, lvl | 8'h01 | ff);
      apb(1'b1, event_timer_pkg::MODE_ADDR, lvl | 8'h81);
   endtask

   task settle;
      repeat (3) @(posedge clk);
   endtask

   // cycles between two pin changes, sampled at rising edges
   task period(output int p);
      logic v;
      int n;
      v = timer_output_pin;
      n = 0;
      while (timer_output_pin === v && n < 40000)
      begin
         @(posedge clk);
         n++;
      end
      v = timer_output_pin;
      n = 0;
      while (timer_output_pin === v && n < 40000)
      begin
         @(posedge clk);
         n++;
      end
      p = n;
   endtask

   task count_high(output int h);
      h = 0;
      repeat (256)
      begin
         @(posedge clk);
         if (timer_output_pin === 1'b1) h++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // hang guard, well above the longest divider measurement
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         num_errors++;
         $display("[ERR] timeout expected finish seen hang");
         summarize();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, event_timer_pkg::MODE_ADDR, 8'h00);
      chk("mode reset", 32'h0, rdata);
      apb(1'b0, event_timer_pkg::CLKSEL_ADDR, 8'h00);
      chk("clksel reset", 32'h0, rdata);
      chk("pin reset", 32'h0, timer_output_pin);
      $display("test reset done");

      apb(1'b1, event_timer_pkg::CLKSEL_ADDR, 8'h07);
      apb(1'b0, event_timer_pkg::CLKSEL_ADDR, 8'h00);
      chk("clksel", 32'h7, rdata);
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h02);
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h03);
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h0b);
      apb(1'b0, event_timer_pkg::MODE_ADDR, 8'h00);
      chk("mode read", 32'h03, rdata);
      settle();
      chk("ff set", 32'h1, timer_output_pin);
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h07);
      settle();
      chk("ff clear", 32'h0, timer_output_pin);
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h0b);
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h0a);
      settle();
      chk("oe off", 32'h0, timer_output_pin);
      apb(1'b0, 32'h0, 8'h00);
      chk("unmapped err", 32'h1, serr);
      chk("unmapped data", 32'h0, rdata);
      $display("test registers done");

      // compare 1: pin toggles every second tick
      apb(1'b1, event_timer_pkg::CMP_ADDR, 8'h01);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h03);
         apb(1'b1, event_timer_pkg::CLKSEL_ADDR, 8'(i + 2));
         mode_seq(8'h02, 8'h04);
         period(per);
         chk("toggle period", 32'(2 * divs[i]), 32'(per));
      end
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h03);
      apb(1'b0, event_timer_pkg::CNT_ADDR, 8'h00);
      chk("stopped count", 32'h0, rdata);
      // inversion off: matches must leave the set flip-flop alone
      apb(1'b1, event_timer_pkg::CLKSEL_ADDR, 8'h02);
      mode_seq(8'h00, 8'h08);
      count_high(highs);
      chk("no inversion", 32'd256, 32'(highs));
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h01);
      $display("test dividers done");

      // external edges; compare kept out of reach
      apb(1'b1, event_timer_pkg::CMP_ADDR, 8'h05);
      for (int e = 0; e < 2; e++)
      begin
         apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h03);
         apb(1'b1, event_timer_pkg::CLKSEL_ADDR, 8'(e));
         mode_seq(8'h02, 8'h04);
         @(posedge clk);
         ext_in <= 1'b1;
         repeat (8) @(posedge clk);
         apb(1'b0, event_timer_pkg::CNT_ADDR, 8'h00);
         chk("after rise", 32'(e), rdata);
         ext_in <= 1'b0;
         repeat (8) @(posedge clk);
         apb(1'b0, event_timer_pkg::CNT_ADDR, 8'h00);
         chk("after fall", 32'h1, rdata);
      end
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h03);
      $display("test external edges done");

      // pwm: 64 of 256 ticks active
      apb(1'b1, event_timer_pkg::CMP_ADDR, 8'h40);
      apb(1'b1, event_timer_pkg::CLKSEL_ADDR, 8'h02);
      mode_seq(8'h40, 8'h00);
      settle();
      count_high(highs);
      chk("pwm high", 32'd64, 32'(highs));
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h41);
      settle();
      chk("pwm stop", 32'h0, timer_output_pin);
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h49);
      settle();
      chk("pwm set ignored", 32'h0, timer_output_pin);
      // back out of pwm with no set/clear: the flip-flop must still be clear
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h01);
      settle();
      chk("ff after pwm set", 32'h0, timer_output_pin);
      mode_seq(8'h42, 8'h00);
      settle();
      count_high(highs);
      chk("pwm low active", 32'd192, 32'(highs));
      apb(1'b1, event_timer_pkg::MODE_ADDR, 8'h43);
      settle();
      chk("pwm stop low", 32'h1, timer_output_pin);
      $display("test pwm done");
      summarize();
   end
endmodule
